// [core/gsc_pkg.sv]
// Shared constants and types of the gain shading calibration block.
package gsc_pkg;
	// Geometry and data widths.
	localparam int NPIX     = 16;
	localparam int IDX_W    = 4;
	localparam int PIX_W    = 12;
	localparam int GAIN_W   = 16;
	localparam int ACC_W    = 19;
	localparam int DIV_W    = 24;
	localparam int FRAC_W   = 12;
	// Calibration needs 2**7 = 128 acquisitions; the average is a shift.
	localparam int NACQ_LOG = 7;
	localparam logic [7:0] NACQ = 8'h80;
	// Gains are 4.12 fixed point; 1.5 is the largest gain the correction can apply.
	localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h1000;
	localparam logic [GAIN_W-1:0] GAIN_MAX   = 16'h1800;
	localparam logic [PIX_W-1:0]  PIX_FULL   = 12'hfff;
	// Register byte offsets.
	localparam logic [7:0] REG_GEN    = 8'h00;
	localparam logic [7:0] REG_CTRL   = 8'h04;
	localparam logic [7:0] REG_FILE   = 8'h08;
	localparam logic [7:0] REG_ROI    = 8'h0c;
	localparam logic [7:0] REG_OFFSET = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	// Field positions.
	localparam int CTRL_CORR_EN  = 0;
	localparam int CTRL_SINGLE   = 1;
	localparam int FILE_SEL      = 0;
	localparam int FILE_ACTIVATE = 4;
	localparam int FILE_COPY     = 8;
	localparam int ROI_LEN_LSB   = 16;
	localparam int STAT_MAX_LSB  = 16;
	// Generate field encodings.
	localparam logic [1:0] GEN_IDLE   = 2'h0;
	localparam logic [1:0] GEN_RAW    = 2'h1;
	localparam logic [1:0] GEN_OFFSET = 2'h2;
	// Reset values.
	localparam logic [1:0]  CTRL_RST = 2'h0;
	localparam logic [IDX_W:0] ROI_LEN_RST = 5'h10;
	// File identifiers.
	localparam logic FILE_FACTORY = 1'b0;
	localparam logic FILE_USER    = 1'b1;

	typedef enum logic [3:0] {
		ST_BOOT, ST_LOAD, ST_IDLE, ST_CLEAR, ST_COLLECT,
		ST_FIND, ST_DIV, ST_DIVW, ST_COPY
	} gsc_state_e;

	// One beat of the pixel stream.
	typedef struct packed {
		logic             line_valid;
		logic             data_valid;
		logic [PIX_W-1:0] data;
	} gsc_pix_s;
endpackage : gsc_pkg

// [core/gsc_div.sv]
// Sequential restoring divider used to form the per-pixel gains.
`timescale 1ns/1ns
`default_nettype none
module gsc_div #(
	parameter int W = 24
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	output var  logic         done,
	output var  logic [W-1:0] quo
);
	logic [W:0]         rem_q;
	logic [W-1:0]       cnt_q;
	logic               run_q;
	logic [W:0]         rem_s;
	logic [W:0]         den_x;

	// One quotient bit per cycle; a zero divisor yields all ones.
	assign rem_s = {rem_q[W-1:0], quo[W-1]};
	assign den_x = {1'b0, den};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rem_q <= '0;
			quo   <= '0;
			cnt_q <= '0;
			run_q <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				rem_q <= '0;
				quo   <= num;
				cnt_q <= W'(W);
				run_q <= 1'b1;
			end else if (run_q) begin
				if (rem_s >= den_x) begin
					rem_q <= rem_s - den_x;
					quo   <= {quo[W-2:0], 1'b1};
				end else begin
					rem_q <= rem_s;
					quo   <= {quo[W-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == 1) begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end
			end
		end
	end
endmodule : gsc_div
`default_nettype wire

// [core/gsc_core.sv]
// Gain shading calibration, file handling and correction with APB access.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
//
// Summary of operation
// - Writing the generate field starts collection.
// - Collect 128 acquisitions before computing gains.
// - Line and data valid keep toggling normally.
// - Bus commands stall while calibration runs.
// - Average each pixel over 128 acquisitions.
// - Brightest averaged pixel is the reference.
// - Gain lifts each pixel to reference.
// - Variants: raw pixels or offset-corrected pixels.
// - Outside region copy previously activated values.
// - Store gains into user file, overwriting.
// - User file becomes activated after generation.
// - Activation copies file into working memory.
// - Correction uses working memory values only.
// - Reload activated file at power-up, reset.
// - Copy command duplicates factory into user.
// - Gain range limited to about 1.5.
// - Separate sets for single-line and others.
module gsc_core (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              por_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire gsc_pkg::gsc_pix_s pix_in,
	output var  gsc_pkg::gsc_pix_s pix_out
);
	import gsc_pkg::*;

	gsc_state_e        state_q;
	logic [1:0]        gen_q;
	logic [1:0]        ctrl_q;
	logic              sel_q;
	logic              nv_act_q;
	logic [IDX_W-1:0]  roi_start_q;
	logic [IDX_W:0]    roi_len_q;
	logic [PIX_W-1:0]  offset_q;
	logic [IDX_W:0]    idx_q;
	logic [7:0]        lines_q;
	logic [IDX_W-1:0]  pidx_q;
	logic              lv_prev_q;
	logic [PIX_W-1:0]  max_q;
	logic              div_start_q;
	logic              div_done;
	logic [DIV_W-1:0]  div_quo;
	logic [GAIN_W-1:0] gain_new;
	logic [PIX_W-1:0]  avg;
	logic [PIX_W-1:0]  pix_cal;
	logic              set_sel;
	logic              in_roi;
	logic [IDX_W+1:0]  roi_end;
	logic              pix_in_roi;
	logic              line_end;
	logic              access;
	logic              take;
	logic              cmd_gen;
	logic              cmd_act;
	logic              cmd_copy;
	logic [27:0]       prod;
	logic [15:0]       scaled;

	logic [GAIN_W-1:0] user_mem [2*NPIX];
	logic [GAIN_W-1:0] work_mem [2*NPIX];
	logic [ACC_W-1:0]  acc_mem  [NPIX];

	// Set 0 serves single-line mode, set 1 every other mode.
	assign set_sel = ~ctrl_q[CTRL_SINGLE];

	// Region test for the calibration scan index and the live pixel; the
	// end is one bit wider so that a long region cannot wrap to zero.
	assign roi_end = {2'b00, roi_start_q} + {1'b0, roi_len_q};
	assign in_roi = ({1'b0, idx_q[IDX_W-1:0]} >= {1'b0, roi_start_q}) &&
		({2'b00, idx_q[IDX_W-1:0]} < roi_end);
	assign pix_in_roi = ({1'b0, pidx_q} >= {1'b0, roi_start_q}) &&
		({2'b00, pidx_q} < roi_end);
	assign line_end = lv_prev_q & ~pix_in.line_valid;

	// Average is the 128-line sum shifted down.
	assign avg = acc_mem[idx_q[IDX_W-1:0]][ACC_W-1:NACQ_LOG];

	// Offset variant subtracts the held offset, saturating at zero.
	assign pix_cal = (gen_q == GEN_OFFSET) ?
		((pix_in.data > offset_q) ? pix_in.data - offset_q : '0) :
		pix_in.data;

	// Clamp the gain: the correction cannot lift pixels far below.
	assign gain_new = (div_quo > {8'h00, GAIN_MAX}) ? GAIN_MAX :
		div_quo[GAIN_W-1:0];

	// Requests are only taken while idle, so commands stall.
	assign access   = psel & penable & ~pready;
	assign take     = access & (state_q == ST_IDLE);
	assign cmd_gen  = take & pwrite & (paddr == REG_GEN) &
		(pwdata[1:0] != GEN_IDLE);
	assign cmd_act  = take & pwrite & (paddr == REG_FILE) &
		pwdata[FILE_ACTIVATE];
	assign cmd_copy = take & pwrite & (paddr == REG_FILE) &
		pwdata[FILE_COPY] & ~pwdata[FILE_ACTIVATE];

	gsc_div #(
		.W(DIV_W)
	) u_div (
		.clk  (pclk),
		.rst_n(presetn),
		.start(div_start_q),
		.num  ({max_q, 12'h000}),
		.den  ({12'h000, avg}),
		.done (div_done),
		.quo  (div_quo)
	);

	// Bus answer: one wait state, offsets above REG_STATUS report an error.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= take;
			pslverr <= take & (paddr > REG_STATUS);
			prdata  <= '0;
			if (take && !pwrite) begin
				unique case (paddr)
					REG_GEN:    prdata <= {30'h0, gen_q};
					REG_CTRL:   prdata <= {30'h0, ctrl_q};
					REG_FILE:   prdata <= {31'h0, nv_act_q};
					REG_ROI:    prdata <= {11'h0, roi_len_q, 12'h0,
						roi_start_q};
					REG_OFFSET: prdata <= {20'h0, offset_q};
					REG_STATUS: prdata <= {4'h0, max_q, 12'h0, state_q};
					default:    prdata <= '0;
				endcase
			end
		end
	end

	// Software configuration registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q      <= CTRL_RST;
			sel_q       <= FILE_FACTORY;
			roi_start_q <= '0;
			roi_len_q   <= ROI_LEN_RST;
			offset_q    <= '0;
		end else if (take && pwrite) begin
			if (paddr == REG_CTRL) begin
				ctrl_q <= pwdata[1:0];
			end
			if (paddr == REG_FILE) begin
				sel_q <= pwdata[FILE_SEL];
			end
			if (paddr == REG_ROI) begin
				roi_start_q <= pwdata[IDX_W-1:0];
				roi_len_q   <= pwdata[ROI_LEN_LSB +: IDX_W+1];
			end
			if (paddr == REG_OFFSET) begin
				offset_q <= pwdata[PIX_W-1:0];
			end
		end
	end

	// Activated-file link lives with the files and survives presetn.
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			nv_act_q <= FILE_FACTORY;
		end else if (state_q == ST_DIV && idx_q[IDX_W]) begin
			nv_act_q <= FILE_USER;
		end else if (cmd_act) begin
			nv_act_q <= pwdata[FILE_SEL];
		end
	end

	// Control sequence: boot load, activation, copy and calibration.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= ST_BOOT;
			gen_q       <= GEN_IDLE;
			idx_q       <= '0;
			lines_q     <= '0;
			max_q       <= '0;
			div_start_q <= 1'b0;
		end else begin
			div_start_q <= 1'b0;
			unique case (state_q)
				ST_BOOT: begin
					idx_q   <= '0;
					state_q <= ST_LOAD;
				end
				ST_LOAD: begin
					idx_q <= idx_q + 1'b1;
					if (idx_q == 5'(2*NPIX-1)) begin
						gen_q   <= GEN_IDLE;
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					idx_q <= '0;
					if (cmd_gen) begin
						gen_q   <= pwdata[1:0];
						state_q <= ST_CLEAR;
					end else if (cmd_act) begin
						state_q <= ST_LOAD;
					end else if (cmd_copy) begin
						state_q <= ST_COPY;
					end
				end
				ST_CLEAR: begin
					lines_q <= '0;
					max_q   <= '0;
					if (!idx_q[IDX_W]) begin
						idx_q <= idx_q + 1'b1;
					end else if (!pix_in.line_valid) begin
						state_q <= ST_COLLECT; // Start on a line boundary.
					end
				end
				ST_COLLECT: begin
					idx_q <= '0;
					if (line_end) begin
						lines_q <= lines_q + 1'b1;
						if (lines_q == NACQ - 8'h01) begin
							state_q <= ST_FIND;
						end
					end
				end
				ST_FIND: begin
					if (in_roi && avg > max_q) begin
						max_q <= avg;
					end
					idx_q <= idx_q + 1'b1;
					if (idx_q == 5'(NPIX-1)) begin
						idx_q   <= '0;
						state_q <= ST_DIV;
					end
				end
				ST_DIV: begin
					if (idx_q[IDX_W]) begin
						idx_q   <= '0;
						state_q <= ST_LOAD;
					end else if (in_roi) begin
						div_start_q <= 1'b1;
						state_q     <= ST_DIVW;
					end else begin
						idx_q <= idx_q + 1'b1;
					end
				end
				ST_DIVW: begin
					if (div_done) begin
						idx_q   <= idx_q + 1'b1;
						state_q <= ST_DIV;
					end
				end
				ST_COPY: begin
					idx_q <= idx_q + 1'b1;
					if (idx_q == 5'(2*NPIX-1)) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// User file: written by calibration and by the factory copy.
	always_ff @(posedge pclk) begin
		if (state_q == ST_COPY) begin
			user_mem[idx_q] <= GAIN_UNITY;
		end else if (state_q == ST_DIVW && div_done) begin
			user_mem[{set_sel, idx_q[IDX_W-1:0]}] <= gain_new;
		end else if (state_q == ST_DIV && !idx_q[IDX_W] && !in_roi) begin
			user_mem[{set_sel, idx_q[IDX_W-1:0]}] <=
				work_mem[{set_sel, idx_q[IDX_W-1:0]}];
		end
	end

	// Working memory is filled from the activated file.
	always_ff @(posedge pclk) begin
		if (state_q == ST_LOAD) begin
			work_mem[idx_q] <= (nv_act_q == FILE_USER) ? user_mem[idx_q] :
				GAIN_UNITY;
		end
	end

	// Per-pixel sums over the calibration lines, region only.
	always_ff @(posedge pclk) begin
		if (state_q == ST_CLEAR && !idx_q[IDX_W]) begin
			acc_mem[idx_q[IDX_W-1:0]] <= '0;
		end else if (state_q == ST_COLLECT && pix_in.line_valid &&
			pix_in.data_valid && pix_in_roi) begin
			acc_mem[pidx_q] <= acc_mem[pidx_q] + ACC_W'(pix_cal);
		end
	end

	// Pixel position within the current line.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pidx_q    <= '0;
			lv_prev_q <= 1'b0;
		end else begin
			lv_prev_q <= pix_in.line_valid;
			if (!pix_in.line_valid) begin
				pidx_q <= '0;
			end else if (pix_in.data_valid) begin
				pidx_q <= pidx_q + 1'b1;
			end
		end
	end

	// Correction multiplies by the working gain and saturates.
	assign prod   = pix_in.data * work_mem[{set_sel, pidx_q}];
	assign scaled = prod[27:FRAC_W];

	// Valid timing passes unchanged even during calibration.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_out <= '0;
		end else begin
			pix_out.line_valid <= pix_in.line_valid;
			pix_out.data_valid <= pix_in.data_valid;
			if (!ctrl_q[CTRL_CORR_EN]) begin
				pix_out.data <= pix_in.data;
			end else if (scaled > {4'h0, PIX_FULL}) begin
				pix_out.data <= PIX_FULL;
			end else begin
				pix_out.data <= scaled[PIX_W-1:0];
			end
		end
	end
endmodule : gsc_core
`default_nettype wire

// [verif/gsc_core_chk.sv]
// Port checker for the gain shading calibration core.
`timescale 1ns/1ns
`default_nettype none
module gsc_core_chk (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire gsc_pkg::gsc_pix_s pix_in,
	input wire gsc_pkg::gsc_pix_s pix_out
);
	import gsc_pkg::*;
	logic       busy_q;
	logic       corr_q;
	logic       lv_q;
	logic [7:0] lines_q;
	wire logic  gen_take;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A calibration start is the edge the generate write is taken.
	assign gen_take = psel && penable && !pready && pwrite &&
		paddr == REG_GEN && pwdata[1:0] != GEN_IDLE;
	// Track a run, the line ends since it began and correction enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q  <= 1'b0;
			corr_q  <= 1'b0;
			lv_q    <= 1'b0;
			lines_q <= 8'h00;
		end else begin
			lv_q <= pix_in.line_valid;
			if (gen_take)
				busy_q <= 1'b1;
			else if (pready && !(pwrite && paddr == REG_GEN))
				busy_q <= 1'b0;
			if (gen_take)
				lines_q <= 8'h00;
			else if (lv_q && !pix_in.line_valid && lines_q != 8'hff)
				lines_q <= lines_q + 8'h01;
			if (pready && pwrite && paddr == REG_CTRL)
				corr_q <= pwdata[CTRL_CORR_EN];
		end
	end
	a_pix_valid: assert property ($past(presetn) |->
		pix_out.line_valid == $past(pix_in.line_valid) &&
		pix_out.data_valid == $past(pix_in.data_valid))
		else $error("valid flags not passed through");
	a_ready_phase: assert property (pready |-> psel && penable)
		else $error("answer outside an access phase");
	a_ready_once: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	a_err_unmapped: assert property (
		pslverr |-> pready && paddr > REG_STATUS)
		else $error("error on a mapped offset");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_gen_wait: assert property (
		pready && busy_q && !pwrite |-> lines_q >= NACQ)
		else $error("bus answered before enough lines");
	a_gen_idle: assert property (pready && busy_q && !pwrite &&
		paddr == REG_GEN |-> prdata[1:0] == GEN_IDLE)
		else $error("generate field not idle after run");
	a_corr_off: assert property ($past(presetn) && !corr_q &&
		$past(pix_in.data_valid) |-> pix_out.data == $past(pix_in.data))
		else $error("data altered with correction off");
	a_gain_ceiling: assert property (!busy_q && !$past(busy_q) &&
		$past(presetn) && pix_out.data_valid |->
		{2'b00, pix_out.data} * 14'h2 <= {2'b00, $past(pix_in.data)} * 14'h3)
		else $error("gain above ceiling");
endmodule : gsc_core_chk
bind gsc_core gsc_core_chk gsc_core_chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pix_in(pix_in), .pix_out(pix_out));
`default_nettype wire

// [verif/gsc_line_src.sv]
// Free-running line source standing in for the sensor readout.
`timescale 1ns/1ns
`default_nettype none
module gsc_line_src (
	input  wire logic        clk,
	input  wire logic        pattern,
	output var  gsc_pkg::gsc_pix_s pix,
	output var  logic [15:0] lines
);
	import gsc_pkg::*;
	int ph = 0;
	// Start quiet so the core sees known levels from time zero.
	initial begin
		pix = '0;
		lines = 16'h0;
	end
	// Sixteen beats a line and a four-cycle gap; the gap inverts the data
	// on every cycle so a stale beat can never pass for a fresh one.
	always @(posedge clk) begin
		ph <= (ph == 19) ? 0 : ph + 1;
		pix.line_valid <= ph < NPIX;
		pix.data_valid <= ph < NPIX;
		if (ph >= NPIX)
			pix.data <= ~pix.data;
		else if (pattern)
			pix.data <= PIX_W'(3000 - 100 * ph);
		else
			pix.data <= PIX_W'($urandom);
		if (ph == NPIX)
			lines <= lines + 16'h1;
	end
endmodule : gsc_line_src
`default_nettype wire

// [verif/gsc_core_bench.sv]
// Self-checking bench of the gain shading calibration core.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
	mismatches++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module gsc_core_bench;
	import gsc_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        por_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pattern = 1'b0;
	logic [15:0] lines;
	gsc_pix_s    pix_in;
	gsc_pix_s    pix_out;
	logic [32:0] eq[$];
	logic [11:0] pq[$];
	logic [32:0] re;
	logic [11:0] pe;
	int          g[NPIX];
	int          mismatches = 0;
	int          tests_run = 0;
	int          idx = 0;
	int          ofs = 0;
	int          l0;
	bit          note_on = 0;

	always #5 pclk = ~pclk;

	gsc_core gsc_core_i (.pclk(pclk), .presetn(presetn), .por_n(por_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pix_in(pix_in), .pix_out(pix_out));
	gsc_line_src gsc_line_src_i (.clk(pclk), .pattern(pattern),
		.pix(pix_in), .lines(lines));

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	// One bus transfer; a read notes its expected {error, data} first.
	task automatic apb_xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] e);
		int n;
		if (!wr)
			eq.push_back(e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			mismatches++;
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb_xfer

	// Gains the core should derive from the calibration pattern; outside
	// the region the copied unity gain is kept.
	function automatic void set_gains(input bit unity, input int rs = 0,
		input int rl = NPIX);
		for (int i = 0; i < NPIX; i++) begin
			g[i] = (3000 - 100 * rs - ofs) * 4096 /
				(3000 - 100 * i - ofs);
			if (unity || i < rs || i >= rs + rl)
				g[i] = int'(GAIN_UNITY);
			else if (g[i] > int'(GAIN_MAX))
				g[i] = int'(GAIN_MAX);
		end
	endfunction : set_gains

	function automatic logic [11:0] f_exp(input int i, input logic [11:0] d);
		int p;
		p = (int'(d) * g[i]) >>> 12;
		return (p > 4095) ? PIX_FULL : p[11:0];
	endfunction : f_exp

	// Flags flip on the falling edge, away from the noting process.
	task automatic run_lines(input int n);
		@(negedge pclk);
		pq.delete();
		note_on = 1;
		repeat (n * 20) @(posedge pclk);
		@(negedge pclk);
		note_on = 0;
		@(posedge pclk);
	endtask : run_lines

	// Note the expected corrected beat for every valid input beat while note_on is set.
	always @(posedge pclk) begin
		if (note_on && pix_in.data_valid)
			pq.push_back(f_exp(idx, pix_in.data));
		idx = !pix_in.line_valid ? 0 : idx + int'(pix_in.data_valid);
	end

	// Take the oldest note whenever a beat or a read answer appears. The
	// falling edge is used: the launching edge has settled by then and the
	// note for that very beat is already queued.
	always @(negedge pclk) begin
		if (pix_out.data_valid === 1'b1 && pq.size() > 0) begin
			pe = pq.pop_front();
			`CHK("pix", pe, pix_out.data)
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			re = eq.pop_front();
			`CHK("prdata", re, {pslverr, prdata})
		end
	end

	initial begin
		void'($urandom(59513));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge pclk);
		set_gains(1);
		apb_xfer(1'b0, REG_CTRL, 32'h0, {1'b0, 32'(CTRL_RST)});
		apb_xfer(1'b0, REG_FILE, 32'h0, {1'b0, 32'(FILE_FACTORY)});
		apb_xfer(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
		apb_xfer(1'b1, REG_CTRL, 32'h1, 33'h0);
		run_lines(3);
		$display("test reset and factory file done");
		for (int m = 1; m <= 2; m++) begin
			ofs = $urandom_range(400);
			apb_xfer(1'b1, REG_OFFSET, 32'(ofs), 33'h0);
			if (m == 1)
				ofs = 0;
			pattern <= 1'b1;
			repeat (40) @(posedge pclk);
			l0 = lines;
			apb_xfer(1'b1, REG_GEN, 32'(m), 33'h0);
			apb_xfer(1'b0, REG_GEN, 32'h0, {1'b0, 32'(GEN_IDLE)});
			`CHK("lines", 1'b1, lines - 16'(l0) >= 16'h0080)
			pattern <= 1'b0;
			apb_xfer(1'b0, REG_FILE, 32'h0, {1'b0, 32'(FILE_USER)});
			set_gains(0);
			run_lines(3);
			$display("test generation %0d done", m);
		end
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb_xfer(1'b0, REG_FILE, 32'h0, {1'b0, 32'(FILE_USER)});
		apb_xfer(1'b1, REG_CTRL, 32'h1, 33'h0);
		run_lines(3);
		$display("test reload after reset done");
		apb_xfer(1'b1, REG_FILE, 32'h10, 33'h0);
		apb_xfer(1'b0, REG_FILE, 32'h0, {1'b0, 32'(FILE_FACTORY)});
		set_gains(1);
		run_lines(3);
		apb_xfer(1'b1, REG_FILE, 32'h100, 33'h0);
		apb_xfer(1'b1, REG_FILE, 32'h11, 33'h0);
		apb_xfer(1'b0, REG_FILE, 32'h0, {1'b0, 32'(FILE_USER)});
		run_lines(3);
		$display("test activate and copy done");
		apb_xfer(1'b1, REG_CTRL, 32'h3, 33'h0);
		apb_xfer(1'b1, REG_ROI, 32'h0008_0004, 33'h0);
		ofs = 0;
		pattern <= 1'b1;
		repeat (40) @(posedge pclk);
		apb_xfer(1'b1, REG_GEN, 32'(GEN_RAW), 33'h0);
		// Hold off the bus for the whole run, as a patient host does.
		repeat (160 * 20) @(posedge pclk);
		apb_xfer(1'b0, REG_STATUS, 32'h0,
			{5'h00, 12'(3000 - 100 * 4), 12'h000, ST_IDLE});
		pattern <= 1'b0;
		set_gains(0, 4, 8);
		run_lines(3);
		apb_xfer(1'b1, REG_CTRL, 32'h1, 33'h0);
		set_gains(1);
		run_lines(3);
		$display("test region and single-line set done");
		final_report();
	end
endmodule : gsc_core_bench
`default_nettype wire
